// >>> inc/tof_pkg.sv
// tof_pkg: constants and types for the telemetry output formatter.
// assumes a 250 MHz system clock; all figures below except STEP_LOAD are used by name.
package tof_pkg;
    // ----------
    // data shapes
    // ----------
    localparam int WORD_W     = 10;
    localparam int STAGE_N    = 3;
    localparam int BUF_W      = WORD_W * STAGE_N;
    localparam int FIFO_DEPTH = 16;
    localparam int STATUS_N   = 16;
    localparam int ADC_W      = 8;
    localparam logic [3:0] SHIFT_LAST = 4'h9;

    // engineering word layout
    localparam int ENG_ADC_LSB    = 0;
    localparam int ENG_STATUS_BIT = 8;
    localparam int ENG_FLAG_BIT   = 9;
    localparam logic [3:0] FLAG_FRAME = 4'h0;

    // ----------
    // timing
    // ----------
    localparam longint CLK_HZ        = 250_000_000;
    localparam longint SLOW_MILLIHZ  = 190_800;
    localparam longint FAST_HZ       = 1060;
    localparam longint ENG_WINDOW_US = 1000;
    localparam longint ENG_STEPS     = 8;
    localparam int SLOW_CYC = int'(CLK_HZ * 1000 / SLOW_MILLIHZ);
    localparam int FAST_CYC = int'(CLK_HZ / FAST_HZ);
    localparam int STEP_CYC = int'(CLK_HZ * ENG_WINDOW_US / 1_000_000 / ENG_STEPS);

    // sequencer step codes
    localparam logic [2:0] STEP_PWR_ON  = 3'h0;
    localparam logic [2:0] STEP_ZERO    = 3'h1;
    localparam logic [2:0] STEP_CONVERT = 3'h2;
    localparam logic [2:0] STEP_LOAD    = 3'h3;
    localparam logic [2:0] STEP_PWR_OFF = 3'h4;
    localparam logic [2:0] STEP_END     = 3'h7;

    typedef enum logic [1:0] {
        TOF_IDLE  = 2'b00,
        TOF_LSHIFT = 2'b01,
        TOF_OSHIFT = 2'b10,
        TOF_PUSH  = 2'b11
    } tof_state_t;
endpackage : tof_pkg

// >>> inc/tof_stream_if.sv
// tof_stream_if: valid/ready word stream between formatter modules.
// assumes producer and consumer share one clock.
`timescale 1ns/10ps
interface tof_stream_if;
    import tof_pkg::*;
    logic              valid;
    logic              ready;
    logic [WORD_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : tof_stream_if

// >>> rtl/tof_fifo.sv
// tof_fifo: flip-flop FIFO, width and depth as parameters.
// assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module tof_fifo #(
    parameter int W = 10,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill and drain sides
    tof_stream_if.snk in_s,
    tof_stream_if.src out_s
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_s.ready  = (cnt_q != (AW+1)'(D));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tof_fifo

// >>> rtl/tof_formatter.sv
// tof_formatter: 30-bit output buffer and engineering sequencer.
// assumes science strobes, frame pulses and adc data on clk_sys;
// demand pins and serial output on the host's link clock.
//
// Contract
// R1: three 10-bit stages chained as 30-bit store
// R2: X, Y, Z each parallel-load stage one
// R3: ten slow shifts after X and Y
// R4: hold static after Z until demand
// R5: science demand shifts stage three, ten pulses
// R6: whole 30-stage chain moves while shifting out
// R7: host demands Y, Z later in frame
// R8: engineering word loaded into stage one per frame
// R9: engineering word gated out from stage one
// R10: divide-by-8 counter steps the converter
// R11: divide-by-16 status counter, one per frame
// R12: status bits load with engineering value
// R13: flag bit every sixteenth frame
// R14: sequence completes within one millisecond window
// R15: buffer supply switched three times per frame; here only seq_supply_on, raised once per frame for the whole window
// R16: one output source chosen per demand
`timescale 1ns/10ps
module tof_formatter #(
    parameter int SLOW_DIV = tof_pkg::SLOW_CYC,
    parameter int FAST_DIV = tof_pkg::FAST_CYC,
    parameter int STEP_DIV = tof_pkg::STEP_CYC
) (
    // system clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // science source
    input  wire logic                         sci_x_load,
    input  wire logic                         sci_y_load,
    input  wire logic                         sci_z_load,
    input  wire logic [tof_pkg::WORD_W-1:0]   sci_data,
    // engineering inputs
    input  wire logic                         eng_start,
    input  wire logic [tof_pkg::ADC_W-1:0]    adc_data,
    input  wire logic [tof_pkg::STATUS_N-1:0] status_bits,
    // converter control
    output wire logic                         adc_power,
    output wire logic                         adc_zero,
    output wire logic                         adc_convert,
    output wire logic                         seq_supply_on,
    // link side
    input  wire logic                         clk_link,
    input  wire logic                         demand,
    input  wire logic                         demand_eng,
    output wire logic                         ser_data,
    output wire logic                         ser_valid
);
    import tof_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    tof_stream_if fill_s ();
    tof_stream_if drain_s ();

    tof_state_t          state_q;
    logic [BUF_W-1:0]    buf_q;
    logic [20:0]         tick_q;
    logic                tick;
    logic [3:0]          bit_q;
    logic                eng_dem_q;
    logic [WORD_W-1:0]   asm_q;
    logic                dem_pend_q;
    logic                dem_pend_eng_q;
    logic [2:0]          dem_tgl_s;
    logic                dem_req;
    logic                dem_take;
    logic                seq_active_q;
    logic [2:0]          step_q;
    logic [14:0]         step_tick_q;
    logic                step_tick;
    logic                eng_load;
    logic [3:0]          stat_cnt_q;
    logic [WORD_W-1:0]   eng_word;
    logic                adc_power_q;
    logic                adc_zero_q;
    logic                adc_convert_q;
    logic                xfer_busy_q;
    logic                xfer_tgl_q;
    logic [WORD_W-1:0]   xfer_word_q;
    logic [2:0]          ack_s;
    // link domain
    logic [1:0]          dem_pin_s;
    logic [1:0]          eng_pin_s;
    logic                dem_last_q;
    logic                dem_tgl_q;
    logic                dem_eng_q;
    logic [2:0]          xfer_s;
    logic [WORD_W-1:0]   lsh_q;
    logic [3:0]          lcnt_q;
    logic                ser_data_q;
    logic                ser_valid_q;
    logic                ack_tgl_q;

    // ------------------------------------------------------------------
    // demand crossing into system domain
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dem_tgl_s <= '0;
        end else begin
            dem_tgl_s <= {dem_tgl_s[1:0], dem_tgl_q};
        end
    end

    assign dem_req  = dem_tgl_s[2] ^ dem_tgl_s[1];
    assign dem_take = (state_q == TOF_IDLE) && dem_pend_q;

    // pending demand; a new request wins over the take
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dem_pend_q     <= 1'b0;
            dem_pend_eng_q <= 1'b0;
        end else if (dem_req) begin
            dem_pend_q     <= 1'b1;
            dem_pend_eng_q <= dem_eng_q;
        end else if (dem_take) begin
            dem_pend_q     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // shift timing
    // ------------------------------------------------------------------
    assign tick = (state_q == TOF_LSHIFT) ? (tick_q == 21'(SLOW_DIV - 1))
                                          : (tick_q == 21'(FAST_DIV - 1));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_q <= '0;
        end else if (state_q == TOF_IDLE || state_q == TOF_PUSH || tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q   <= TOF_IDLE;
            bit_q     <= '0;
            eng_dem_q <= 1'b0;
        end else begin
            case (state_q)
                TOF_IDLE: begin
                    bit_q <= '0;
                    if (sci_x_load || sci_y_load) begin
                        state_q <= TOF_LSHIFT;                      // [R3]
                    end else if (dem_take) begin
                        state_q   <= TOF_OSHIFT;                    // [R4]
                        eng_dem_q <= dem_pend_eng_q;                // [R16]
                    end
                end
                TOF_LSHIFT, TOF_OSHIFT: begin
                    if (tick) begin
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == SHIFT_LAST) begin
                            state_q <= (state_q == TOF_OSHIFT) ? TOF_PUSH
                                                               : TOF_IDLE;
                        end
                    end
                end
                TOF_PUSH: begin
                    if (fill_s.ready) begin
                        state_q <= TOF_IDLE;
                    end
                end
                default: begin
                    state_q <= TOF_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // 30-bit store: stage one [9:0], two [19:10], three [29:20]
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buf_q <= '0;
            asm_q <= '0;
        end else begin
            case (state_q)
                TOF_IDLE: begin
                    if (sci_x_load || sci_y_load || sci_z_load) begin
                        buf_q[WORD_W-1:0] <= sci_data;              // [R2]
                    end else if (eng_load) begin
                        buf_q[WORD_W-1:0] <= eng_word;              // [R8]
                    end
                end
                TOF_LSHIFT: begin
                    if (tick) begin
                        buf_q <= {buf_q[BUF_W-2:0], 1'b0};          // [R1] [R3]
                    end
                end
                TOF_OSHIFT: begin
                    if (tick && eng_dem_q) begin
                        asm_q <= {asm_q[WORD_W-2:0], buf_q[WORD_W-1]}; // [R9] [R16]
                        buf_q[WORD_W-1:0] <= {buf_q[WORD_W-2:0], 1'b0};
                    end else if (tick) begin
                        asm_q <= {asm_q[WORD_W-2:0], buf_q[BUF_W-1]}; // [R5] [R16]
                        buf_q <= {buf_q[BUF_W-2:0], 1'b0};          // [R6]
                    end
                end
                default: begin
                    buf_q <= buf_q;
                end
            endcase
        end
    end

    assign fill_s.valid = (state_q == TOF_PUSH);
    assign fill_s.data  = asm_q;

    // ------------------------------------------------------------------
    // output FIFO
    // ------------------------------------------------------------------
    tof_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .in_s    (fill_s),
        .out_s   (drain_s)
    );

    // ------------------------------------------------------------------
    // word handshake toward link domain
    // ------------------------------------------------------------------
    assign drain_s.ready = !xfer_busy_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_s <= '0;
        end else begin
            ack_s <= {ack_s[1:0], ack_tgl_q};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xfer_busy_q <= 1'b0;
            xfer_tgl_q  <= 1'b0;
            xfer_word_q <= '0;
        end else if (!xfer_busy_q && drain_s.valid) begin
            xfer_busy_q <= 1'b1;
            xfer_tgl_q  <= ~xfer_tgl_q;
            xfer_word_q <= drain_s.data;
        end else if (ack_s[2] ^ ack_s[1]) begin
            xfer_busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // engineering sequencer
    // ------------------------------------------------------------------
    assign step_tick = (step_tick_q == 15'(STEP_DIV - 1));
    assign eng_load  = seq_active_q && step_tick && (step_q == STEP_CONVERT);
    assign eng_word  = {(stat_cnt_q == FLAG_FRAME),                 // [R13]
                        status_bits[stat_cnt_q],                    // [R12]
                        adc_data};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seq_active_q <= 1'b0;
            step_q       <= STEP_PWR_ON;
            step_tick_q  <= '0;
        end else if (!seq_active_q) begin
            step_tick_q <= '0;
            step_q      <= STEP_PWR_ON;
            if (eng_start) begin
                seq_active_q <= 1'b1;
            end
        end else if (step_tick) begin
            step_tick_q <= '0;
            step_q      <= step_q + 1'b1;                           // [R10]
            if (step_q == STEP_END) begin
                seq_active_q <= 1'b0;                               // [R14]
            end
        end else begin
            step_tick_q <= step_tick_q + 1'b1;
        end
    end

    // status counter advances once per frame at the load
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_cnt_q <= '0;
        end else if (eng_load) begin
            stat_cnt_q <= stat_cnt_q + 1'b1;                        // [R11]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            adc_power_q   <= 1'b0;
            adc_zero_q    <= 1'b0;
            adc_convert_q <= 1'b0;
        end else begin
            adc_power_q   <= seq_active_q && (step_q < STEP_PWR_OFF);  // [R10]
            adc_zero_q    <= seq_active_q && (step_q == STEP_ZERO);
            adc_convert_q <= seq_active_q && (step_q == STEP_CONVERT);
        end
    end

    assign adc_power     = adc_power_q;
    assign adc_zero      = adc_zero_q;
    assign adc_convert   = adc_convert_q;
    assign seq_supply_on = seq_active_q;                            // [R14]

    // ------------------------------------------------------------------
    // link domain: demand capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            dem_pin_s  <= '0;
            eng_pin_s  <= '0;
            dem_last_q <= 1'b0;
        end else begin
            dem_pin_s  <= {dem_pin_s[0], demand};
            eng_pin_s  <= {eng_pin_s[0], demand_eng};
            dem_last_q <= dem_pin_s[1];
        end
    end

    // each rising demand becomes one toggle with its kind beside it
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            dem_tgl_q <= 1'b0;
            dem_eng_q <= 1'b0;
        end else if (dem_pin_s[1] && !dem_last_q) begin
            dem_tgl_q <= ~dem_tgl_q;                                // [R7]
            dem_eng_q <= eng_pin_s[1];
        end
    end

    // ------------------------------------------------------------------
    // link domain: serial output
    // ------------------------------------------------------------------
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            xfer_s <= '0;
        end else begin
            xfer_s <= {xfer_s[1:0], xfer_tgl_q};
        end
    end

    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            lsh_q       <= '0;
            lcnt_q      <= '0;
            ser_data_q  <= 1'b0;
            ser_valid_q <= 1'b0;
            ack_tgl_q   <= 1'b0;
        end else if (lcnt_q != '0) begin
            ser_data_q  <= lsh_q[WORD_W-1];
            ser_valid_q <= 1'b1;
            lsh_q       <= {lsh_q[WORD_W-2:0], 1'b0};
            lcnt_q      <= lcnt_q - 1'b1;
            if (lcnt_q == 4'h1) begin
                ack_tgl_q <= ~ack_tgl_q;
            end
        end else if (xfer_s[2] ^ xfer_s[1]) begin
            lsh_q       <= xfer_word_q;
            lcnt_q      <= SHIFT_LAST + 1'b1;
            ser_valid_q <= 1'b0;
        end else begin
            ser_valid_q <= 1'b0;
        end
    end

    assign ser_data  = ser_data_q;
    assign ser_valid = ser_valid_q;
endmodule : tof_formatter

// >>> verification/tof_formatter_asserts.sv
// tof_formatter_asserts: port-level checks for the telemetry output formatter.
// assumes binding into tof_formatter; rst clears both clock domains.
`timescale 1ns/10ps
module tof_formatter_asserts #(
    parameter int STEP_DIV = tof_pkg::STEP_CYC
) (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic clk_link,
    input wire logic rst,
    // converter control
    input wire logic adc_power,
    input wire logic adc_zero,
    input wire logic adc_convert,
    input wire logic seq_supply_on,
    // link side
    input wire logic demand,
    input wire logic ser_valid
);
    import tof_pkg::*;
    // ----------
    // helper counters
    // ----------
    logic [31:0] zero_cnt_q;
    logic [31:0] sup_cnt_q;
    logic [3:0]  val_cnt_q;
    logic [3:0]  dem_cnt_q;
    logic        dem_d_q;
    logic        dem_rise;
    logic        val_rise;
    assign dem_rise = demand & ~dem_d_q;
    assign val_rise = ser_valid & (val_cnt_q == 4'h0);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zero_cnt_q <= '0;
            sup_cnt_q  <= '0;
        end else begin
            zero_cnt_q <= adc_zero ? zero_cnt_q + 32'h1 : 32'h0;
            sup_cnt_q  <= seq_supply_on ? sup_cnt_q + 32'h1 : 32'h0;
        end
    end
    // outstanding demands not yet answered by a word
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            val_cnt_q <= '0;
            dem_cnt_q <= '0;
            dem_d_q   <= 1'b0;
        end else begin
            val_cnt_q <= ser_valid ? val_cnt_q + 4'h1 : 4'h0;
            dem_cnt_q <= dem_cnt_q + {3'h0, dem_rise} - {3'h0, val_rise};
            dem_d_q   <= demand;
        end
    end
    // ----------
    // checks
    // ----------
    AST_ZERO_IN_POWER: assert property (@(posedge clk_sys) disable iff (rst)
        adc_zero |-> adc_power) else $error("zero correction without power");
    AST_CONVERT_ALONE: assert property (@(posedge clk_sys) disable iff (rst)
        adc_convert |-> adc_power && !adc_zero) else $error("convert overlaps zero step");
    AST_ZERO_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(adc_zero) |-> zero_cnt_q == 32'(STEP_DIV)) else $error("zero step length");
    AST_ZERO_THEN_CONVERT: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(adc_zero) |-> adc_convert) else $error("convert not after zero step");
    AST_POWER_FALL: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(adc_power) |-> !adc_convert && seq_supply_on) else $error("power off early");
    AST_POWER_IN_SUPPLY: assert property (@(posedge clk_sys) disable iff (rst)
        adc_power |-> seq_supply_on) else $error("converter powered outside window");
    AST_SUPPLY_LEN: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(seq_supply_on) |-> sup_cnt_q == 32'(8 * STEP_DIV)) else $error("window length");
    AST_WORD_LEN: assert property (@(posedge clk_link) disable iff (rst)
        $fell(ser_valid) |-> val_cnt_q == 4'hA) else $error("word not ten bits long");
    AST_NO_UNDEMANDED: assert property (@(posedge clk_link) disable iff (rst)
        $rose(ser_valid) |-> dem_cnt_q != 4'h0) else $error("word sent without demand");
    COV_WORD: cover property (@(posedge clk_link) disable iff (rst) $fell(ser_valid));
    COV_CONVERT: cover property (@(posedge clk_sys) disable iff (rst) $fell(adc_convert));
    COV_WINDOW: cover property (@(posedge clk_sys) disable iff (rst) $fell(seq_supply_on));
endmodule : tof_formatter_asserts

bind tof_formatter tof_formatter_asserts #(.STEP_DIV(STEP_DIV)) u_asserts (
    .clk_sys, .clk_link, .rst, .adc_power, .adc_zero, .adc_convert,
    .seq_supply_on, .demand, .ser_valid
);

// >>> verification/tof_host_model.sv
// tof_host_model: telemetry host issuing demand pulses and taking words.
// assumes clk_link is free running and made by the bench.
`timescale 1ns/10ps
module tof_host_model (
    // link clock
    input  wire logic clk_link,
    // demand pins
    output logic      demand,
    output logic      demand_eng,
    // serial return
    input  wire logic ser_data,
    input  wire logic ser_valid
);
    import tof_pkg::*;
    initial {demand, demand_eng} = 2'b00;
    // one demand, then collect ten bits msb first
    task automatic fetch(input logic eng, output logic [WORD_W-1:0] w, output logic ok);
        int n;
        w  = '0;
        ok = 1'b1;
        n  = 0;
        @(posedge clk_link);
        demand     <= 1'b1;
        demand_eng <= eng;
        repeat (4) @(posedge clk_link);
        demand     <= 1'b0;
        demand_eng <= ~eng;
        @(negedge clk_link);
        while (ser_valid !== 1'b1 && n < 500) begin
            @(negedge clk_link);
            n++;
        end
        for (int i = 0; i < WORD_W; i++) begin
            ok &= (ser_valid === 1'b1);
            w = {w[WORD_W-2:0], ser_data};
            @(negedge clk_link);
        end
        ok &= (ser_valid === 1'b0);
    endtask : fetch
endmodule : tof_host_model

// >>> verification/tof_formatter_tb_top.sv
// tof_formatter_tb_top: directed bench for the telemetry output formatter.
// assumes tof_host_model on the link side and the bound port checker.
`timescale 1ns/10ps
module tof_formatter_tb_top;
    import tof_pkg::*;
    localparam int SLOW = 8;
    localparam int FAST = 4;
    localparam int STEP = 6;
    localparam logic [15:0] STAT = 16'hA53C;
    logic                clk_sys, clk_link, rst, eng_start;
    logic                sci_x_load, sci_y_load, sci_z_load;
    logic [WORD_W-1:0]   sci_data;
    logic [ADC_W-1:0]    adc_data;
    logic [STATUS_N-1:0] status_bits;
    logic                adc_power, adc_zero, adc_convert, seq_supply_on;
    logic                demand, demand_eng, ser_data, ser_valid;
    int                  miscompares = 0;
    int                  checked = 0;
    int                  cycles = 0;

    tof_formatter #(.SLOW_DIV(SLOW), .FAST_DIV(FAST), .STEP_DIV(STEP)) u_dut (
        .clk_sys, .rst, .sci_x_load, .sci_y_load, .sci_z_load, .sci_data, .eng_start,
        .adc_data, .status_bits, .adc_power, .adc_zero, .adc_convert, .seq_supply_on,
        .clk_link, .demand, .demand_eng, .ser_data, .ser_valid
    );
    tof_host_model u_host (.clk_link, .demand, .demand_eng, .ser_data, .ser_valid);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3.7;
        forever #16 clk_link = ~clk_link;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ----------
    // compare and drive helpers
    // ----------
    task automatic chk_word(input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t word exp %h got %h", $time, exp, got);
        end
    endtask : chk_word
    task automatic chk_count(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t count exp %0d got %0d", $time, exp, got);
        end
    endtask : chk_count
    task automatic load_word(input int sel, input logic [WORD_W-1:0] d);
        @(posedge clk_sys);
        sci_data   <= d;
        sci_x_load <= (sel == 0);
        sci_y_load <= (sel == 1);
        sci_z_load <= (sel == 2);
        @(posedge clk_sys);
        {sci_x_load, sci_y_load, sci_z_load} <= 3'h0;
        sci_data <= ~d;
        repeat (10 * SLOW + 4) @(posedge clk_sys);
    endtask : load_word
    // one engineering window, step lengths counted at the pins
    task automatic eng_frame(input logic [ADC_W-1:0] adc);
        logic [15:0] n_pwr, n_zero, n_conv, n_sup;
        {n_pwr, n_zero, n_conv, n_sup} = '0;
        @(posedge clk_sys);
        adc_data  <= adc;
        eng_start <= 1'b1;
        @(posedge clk_sys);
        eng_start <= 1'b0;
        repeat (8 * STEP + 6) begin
            @(negedge clk_sys);
            n_pwr  += {15'h0, adc_power};
            n_zero += {15'h0, adc_zero};
            n_conv += {15'h0, adc_convert};
            n_sup  += {15'h0, seq_supply_on};
        end
        chk_count(16'(4 * STEP), n_pwr);
        chk_count(16'(STEP), n_zero);
        chk_count(16'(STEP), n_conv);
        chk_count(16'(8 * STEP), n_sup);
        @(posedge clk_sys);
        adc_data <= ~adc;
    endtask : eng_frame
    function automatic logic [WORD_W-1:0] eng_word(input int f, input logic [ADC_W-1:0] adc);
        logic [WORD_W-1:0] w;
        w = '0;
        w[ENG_FLAG_BIT]         = (4'(f) == FLAG_FRAME);
        w[ENG_STATUS_BIT]       = STAT[f % 16];
        w[ENG_ADC_LSB +: ADC_W] = adc;
        return w;
    endfunction : eng_word
    task automatic read_word(input logic eng, input logic [WORD_W-1:0] exp);
        logic [WORD_W-1:0] w;
        logic              ok;
        u_host.fetch(eng, w, ok);
        chk_count(16'h1, {15'h0, ok});
        chk_word(exp, w);
    endtask : read_word
    // ----------
    // scenarios
    // ----------
    task automatic t_interleave;
        load_word(0, 10'h3A5);
        load_word(1, 10'h15C);
        load_word(2, 10'h2C3);
        repeat (300) @(posedge clk_sys);
        read_word(1'b0, 10'h3A5);
        eng_frame(8'hC6);
        read_word(1'b1, eng_word(0, 8'hC6));
        read_word(1'b0, 10'h15C);
        read_word(1'b0, 10'h2C3);
    endtask : t_interleave
    task automatic t_status_cycle;
        for (int f = 1; f <= 16; f++) begin
            eng_frame(8'(f) ^ 8'h5A);
            read_word(1'b1, eng_word(f, 8'(f) ^ 8'h5A));
        end
    endtask : t_status_cycle
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        rst = 1'b1;
        {sci_x_load, sci_y_load, sci_z_load, eng_start} = 4'h0;
        sci_data    = 10'h000;
        adc_data    = 8'h00;
        status_bits = STAT;
        repeat (8) @(posedge clk_sys);
        repeat (2) @(posedge clk_link);
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (40) @(posedge clk_sys);
        t_interleave();
        t_status_cycle();
        give_verdict();
    end
endmodule : tof_formatter_tb_top
